// ==== logic/lsm_multiplexer.sv ====
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Segment shows latch k during phase k.
// - Three-way mode skips phase four; fourth latches unused.
// - Backplane n is active only during phase n.
// - Each latch location is chosen from 40 display locations.
// - Each latch bus bit is chosen from the four nibble bits.
// - Default: segment s latch k takes bit k at location s.
// - Strobe route bits 3:2 of control one cleared only by power-on reset.
// - Pump clock select bits 1:0 pick prescaler tap 10, 9, 8 or 7.
// - Control two holds blank, off, four-way, external bias; first three reset to one.
// - Blank forces all segment outputs off.
// - Off disables the display and stops the voltage multiplier.
// - External bias select cleared only by power-on reset.
// - Windows one and two at 0x44, 0x45, indexed by pointer at 0x70.
// - Window three at 0x46 exposes index 0 to 7 only.
// - Window three index 8 to 15 holds no storage.
// - Three-way mode keeps the fourth backplane inactive.
// - Off keeps latch contents and pulls bias outputs to ground.
// - Blank leaves multiplier and regulator running.
// - Sequencer steps at a 256 Hz display clock.
module lsm_multiplexer #(
    parameter int NUM_SEG = lsm_pkg::NUM_SEG,
    // Default map: latch index s*4+k sits at location s, bus bit k.
    parameter lsm_pkg::lsm_latch_cfg_t [lsm_pkg::NUM_SEG*lsm_pkg::NUM_PH-1:0] LATCH_CFG =
        lsm_default_cfg()
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic por,
    input wire logic [lsm_pkg::TAP_W-1:0] prescaler_tap,
    input wire logic [lsm_pkg::ADDR_W-1:0] addr,
    input wire logic [lsm_pkg::NIB_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [lsm_pkg::NIB_W-1:0] rdata,
    output logic [lsm_pkg::NUM_SEG-1:0] segment_out,
    output logic [lsm_pkg::NUM_PH-1:0] backplane_out,
    output lsm_pkg::lsm_power_t power,
    output logic [2:0] bias_ground
);
    import lsm_pkg::*;

    localparam int NL = NUM_SEG * NUM_PH;

    function automatic lsm_latch_cfg_t [NUM_SEG*NUM_PH-1:0] lsm_default_cfg();
        lsm_latch_cfg_t [NUM_SEG*NUM_PH-1:0] c;
        for (int s = 0; s < NUM_SEG; s++) begin
            for (int k = 0; k < NUM_PH; k++) begin
                c[s*NUM_PH+k].loc = LOC_W'(s);
                c[s*NUM_PH+k].bit_sel = 2'(k);
            end
        end
        return c;
    endfunction

    // Maps a window address and index to a location; invalid gives valid low.
    function automatic logic [LOC_W:0] win_loc(input logic [ADDR_W-1:0] a,
                                               input logic [NIB_W-1:0] ix);
        logic [LOC_W:0] r;
        r = '0;
        if (a == ADDR_WIN_ONE) begin
            r = {1'b1, LOC_BASE_ONE + LOC_W'(ix)};
        end else if (a == ADDR_WIN_TWO) begin
            r = {1'b1, LOC_BASE_TWO + LOC_W'(ix)};
        end else if (a == ADDR_WIN_THREE && ix < WIN_THREE_LIMIT) begin
            r = {1'b1, LOC_BASE_THREE + LOC_W'(ix)};
        end
        return r;
    endfunction

    // Synchronised prescaler taps; they come from another block's pins.
    logic [TAP_W-1:0] tap_s1_r;
    logic [TAP_W-1:0] tap_s2_r;
    logic [TAP_W-1:0] tap_d_r;

    logic [NIB_W-1:0] index_r;
    logic [1:0] pump_sel_r;
    logic [1:0] strobe_r;
    logic blank_r;
    logic off_r;
    logic four_r;
    logic ext_r;
    logic [NL-1:0] latch_r;
    logic [NIB_W-1:0] rdata_r;
    logic [NIB_W-1:0] rdata_nxt;
    logic [NUM_SEG-1:0] seg_r;
    logic [NUM_SEG-1:0] seg_nxt;
    logic pump_r;

    wire logic [LOC_W:0] acc_loc;
    wire logic acc_hit;
    wire logic disp_step;
    wire logic pump_src;
    wire logic sel_ctrl_one;
    wire logic sel_ctrl_two;
    wire logic sel_index;
    wire lsm_phase_t phase;
    wire logic run;

    assign acc_loc = win_loc(addr, index_r);
    assign acc_hit = acc_loc[LOC_W];
    assign sel_ctrl_one = (addr == ADDR_CTRL_ONE);
    assign sel_ctrl_two = (addr == ADDR_CTRL_TWO);
    assign sel_index = (addr == ADDR_INDEX);

    // Rising edge of the 256 Hz tap steps the sequencer.
    assign disp_step = tap_s2_r[TAP_DISPLAY] & ~tap_d_r[TAP_DISPLAY];
    // The select value counts taps below tap 10, so bit 0 alone gives tap 9.
    assign pump_src = tap_s2_r[TAP_PUMP_BASE - int'(pump_sel_r)];
    assign run = ~off_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tap_s1_r <= '0;
            tap_s2_r <= '0;
            tap_d_r <= '0;
        end else begin
            tap_s1_r <= prescaler_tap;
            tap_s2_r <= tap_s1_r;
            tap_d_r <= tap_s2_r;
        end
    end

    // Power-on-only bits live on their own reset.
    always_ff @(posedge clock or posedge por) begin
        if (por) begin
            strobe_r <= STROBE_POR;
            ext_r <= EXT_POR;
        end else if (wr && sel_ctrl_one) begin
            strobe_r <= {wdata[C1_STROBE_HI], wdata[C1_STROBE_LO]};
        end else if (wr && sel_ctrl_two) begin
            ext_r <= wdata[C2_EXT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_r <= '0;
            pump_sel_r <= C1_PUMP_RESET;
            {blank_r, off_r, four_r} <= C2_LOGIC_RESET;
        end else if (wr) begin
            if (sel_index) begin
                index_r <= wdata;
            end
            if (sel_ctrl_one) begin
                pump_sel_r <= {wdata[C1_PUMP_HI], wdata[C1_PUMP_LO]};
            end
            if (sel_ctrl_two) begin
                blank_r <= wdata[C2_BLANK];
                off_r <= wdata[C2_OFF];
                four_r <= wdata[C2_FOUR];
            end
        end
    end

    // Latches have no reset so their contents survive any reset and off.
    always_ff @(posedge clock) begin
        for (int i = 0; i < NL; i++) begin
            if (wr && acc_hit && LATCH_CFG[i].loc == acc_loc[LOC_W-1:0]) begin
                latch_r[i] <= wdata[LATCH_CFG[i].bit_sel];
            end
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (sel_index) begin
            rdata_nxt = index_r;
        end else if (sel_ctrl_one) begin
            rdata_nxt = {strobe_r, pump_sel_r};
        end else if (sel_ctrl_two) begin
            rdata_nxt = {blank_r, off_r, four_r, ext_r};
        end else if (acc_hit) begin
            for (int i = 0; i < NL; i++) begin
                if (LATCH_CFG[i].loc == acc_loc[LOC_W-1:0]) begin
                    rdata_nxt[LATCH_CFG[i].bit_sel] = latch_r[i];
                end
            end
        end
    end

    // Segment data for the upcoming phase; blank and off force all off.
    always_comb begin
        seg_nxt = '0;
        for (int s = 0; s < NUM_SEG; s++) begin
            seg_nxt[s] = latch_r[s*NUM_PH + int'(phase)];
        end
        if (blank_r || off_r || (!four_r && phase == PH_FOUR)) begin
            seg_nxt = '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
            seg_r <= '0;
            pump_r <= 1'b0;
        end else begin
            rdata_r <= rd ? rdata_nxt : '0;
            seg_r <= seg_nxt;
            pump_r <= run & pump_src;
        end
    end

    lsm_phase_seq u_seq (
        .clock(clock),
        .rst(rst),
        .step(disp_step & run),
        .four_way_multiplex(four_r),
        .run(run),
        .phase(phase),
        .backplane_out(backplane_out)
    );

    assign rdata = rdata_r;
    assign segment_out = seg_r;
    // One assignment drives the whole struct so the output has a single driver.
    assign power = '{
        enable: run,
        shutdown: off_r,
        external_bias_select: ext_r,
        pump_clock: pump_r,
        strobe_route: strobe_r
    };
    assign bias_ground = {3{off_r}};

endmodule

`default_nettype wire

// ==== logic/lsm_pkg.sv ====
package lsm_pkg;

    localparam int NIB_W = 4;
    localparam int ADDR_W = 8;
    localparam int NUM_SEG = 20;
    localparam int NUM_PH = 4;
    localparam int NUM_LOC = 40;
    localparam int LOC_W = 6;
    localparam int TAP_W = 15;

    // Peripheral addresses of the display windows, the index pointer and the two control registers.
    localparam logic [ADDR_W-1:0] ADDR_WIN_ONE = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_WIN_TWO = 8'h45;
    localparam logic [ADDR_W-1:0] ADDR_WIN_THREE = 8'h46;
    localparam logic [ADDR_W-1:0] ADDR_INDEX = 8'h70;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 8'h48;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 8'h49;

    // Location base of each window inside the 40-location space.
    localparam logic [LOC_W-1:0] LOC_BASE_ONE = 6'h00;
    localparam logic [LOC_W-1:0] LOC_BASE_TWO = 6'h10;
    localparam logic [LOC_W-1:0] LOC_BASE_THREE = 6'h20;
    localparam logic [NIB_W-1:0] WIN_THREE_LIMIT = 4'h8;

    // Control one field positions.
    localparam int C1_STROBE_HI = 3;
    localparam int C1_STROBE_LO = 2;
    localparam int C1_PUMP_HI = 1;
    localparam int C1_PUMP_LO = 0;
    // Control two field positions.
    localparam int C2_BLANK = 3;
    localparam int C2_OFF = 2;
    localparam int C2_FOUR = 1;
    localparam int C2_EXT = 0;

    localparam logic [1:0] C1_PUMP_RESET = 2'h0;
    localparam logic [2:0] C2_LOGIC_RESET = 3'h7;
    localparam logic [1:0] STROBE_POR = 2'h0;
    localparam logic EXT_POR = 1'h0;

    // Prescaler tap positions for display and pump clocks.
    localparam int TAP_DISPLAY = 9;
    localparam int TAP_PUMP_BASE = 10;

    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } lsm_phase_t;

    // Configuration of one segment data latch: location and bus bit.
    typedef struct packed {
        logic [LOC_W-1:0] loc;
        logic [1:0] bit_sel;
    } lsm_latch_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [NIB_W-1:0] wdata;
        logic wr;
        logic rd;
    } lsm_bus_req_t;

    typedef struct packed {
        logic enable;
        logic shutdown;
        logic external_bias_select;
        logic pump_clock;
        logic [1:0] strobe_route;
    } lsm_power_t;

endpackage

// ==== logic/lsm_phase_seq.sv ====
`timescale 1ns/100ps
`default_nettype none

module lsm_phase_seq (
    input wire logic clock,
    input wire logic rst,
    input wire logic step,
    input wire logic four_way_multiplex,
    input wire logic run,
    output lsm_pkg::lsm_phase_t phase,
    output logic [lsm_pkg::NUM_PH-1:0] backplane_out
);
    import lsm_pkg::*;

    lsm_phase_t phase_r;
    lsm_phase_t phase_nxt;
    logic [NUM_PH-1:0] bp_r;
    logic [NUM_PH-1:0] bp_nxt;
    wire logic last_phase;

    // Three-way mode wraps after phase three, four-way after phase four.
    assign last_phase = four_way_multiplex ? (phase_r == PH_FOUR) : (phase_r == PH_THREE);

    always_comb begin
        phase_nxt = phase_r;
        if (step) begin
            if (last_phase) begin
                phase_nxt = PH_ONE;
            end else begin
                case (phase_r)
                    PH_ONE: phase_nxt = PH_TWO;
                    PH_TWO: phase_nxt = PH_THREE;
                    PH_THREE: phase_nxt = PH_FOUR;
                    default: phase_nxt = PH_ONE;
                endcase
            end
        end
    end

    // One backplane per phase, fourth held off in three-way mode.
    always_comb begin
        bp_nxt = '0;
        if (run) begin
            bp_nxt[phase_nxt] = 1'b1;
        end
        if (!four_way_multiplex) begin
            bp_nxt[NUM_PH-1] = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r <= PH_ONE;
            bp_r <= '0;
        end else begin
            phase_r <= phase_nxt;
            bp_r <= bp_nxt;
        end
    end

    // The phase handed out is the one the backplanes move to, so the segment data
    // registered from it changes on the same edge as the backplanes.
    assign phase = phase_nxt;
    assign backplane_out = bp_r;

endmodule

`default_nettype wire

// ==== test/lsm_multiplexer_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

module lsm_multiplexer_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [3:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] rdata,
    input wire logic [19:0] segment_out,
    input wire logic [3:0] backplane_out,
    input wire lsm_pkg::lsm_power_t power,
    input wire logic [2:0] bias_ground
);
    import lsm_pkg::*;
    // Shadow of blank, off and four-way, taken from the writes themselves.
    logic [2:0] mode_r;
    wire ctl2_wr = wr && addr == ADDR_CTRL_TWO;
    wire blank = mode_r[2];
    wire off = mode_r[1];
    wire four = mode_r[0];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r <= 3'h7;
        end else if (ctl2_wr) begin
            mode_r <= wdata[3:1];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    rd_quiet_a: assert property (rdata != 4'h0 |-> $past(rd))
        else $error("read data without a read");
    bp_onehot_a: assert property ($onehot0(backplane_out))
        else $error("more than one backplane active");
    bp_step_a: assert property (backplane_out != $past(backplane_out)
        && backplane_out != 4'h0 && $past(backplane_out) != 4'h0
        |-> backplane_out == 4'h1 || backplane_out == ($past(backplane_out) << 1))
        else $error("backplane skipped a phase");
    three_way_a: assert property (!four && $past(!four) |-> !backplane_out[3])
        else $error("fourth backplane active in three-way mode");
    blank_seg_a: assert property (blank && $past(blank) |-> segment_out == 20'h0)
        else $error("segment on while blanked");
    off_dark_a: assert property (off && $past(off)
        |-> backplane_out == 4'h0 && power.shutdown)
        else $error("display running while off");
    off_bias_a: assert property (off == $past(off) |-> bias_ground == {3{off}})
        else $error("bias grounding does not follow off");
    pump_run_a: assert property (!off && $past(!off) |-> !power.shutdown)
        else $error("multiplier stopped while on");
    pump_off_a: assert property (off && $past(off) |-> !power.pump_clock)
        else $error("multiplier clock running while off");
endmodule

bind lsm_multiplexer lsm_multiplexer_chk lsm_multiplexer_chk_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .segment_out(segment_out), .backplane_out(backplane_out),
    .power(power), .bias_ground(bias_ground));

`default_nettype wire

// ==== test/lsm_glass.sv ====
`timescale 1ns/100ps
`default_nettype none

module lsm_glass (
    input wire logic clock,
    input wire logic [19:0] segment_out,
    input wire logic [3:0] backplane_out,
    output logic [3:0][19:0] rows
);
    // A pixel keeps what it saw while its backplane was active; with no
    // backplane driven the whole glass relaxes to dark.
    always_ff @(posedge clock) begin
        for (int k = 0; k < 4; k++) begin
            if (backplane_out == 4'h0) rows[k] <= 20'h0;
            else if (backplane_out[k]) rows[k] <= segment_out;
        end
    end
endmodule

`default_nettype wire

// ==== test/lsm_multiplexer_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

module lsm_multiplexer_bench;
    import lsm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic [14:0] prescaler_tap = 15'h0;
    logic [7:0] addr = 8'h0;
    logic [3:0] wdata = 4'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] rdata;
    logic [19:0] segment_out;
    logic [3:0] backplane_out;
    lsm_power_t power;
    logic [2:0] bias_ground;
    logic [3:0][19:0] rows;
    logic [3:0] shadow [20];
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    lsm_multiplexer lsm_multiplexer_i (.clock(clock), .rst(rst), .por(por),
        .prescaler_tap(prescaler_tap), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .segment_out(segment_out),
        .backplane_out(backplane_out), .power(power), .bias_ground(bias_ground));
    lsm_glass lsm_glass_i (.clock(clock), .segment_out(segment_out),
        .backplane_out(backplane_out), .rows(rows));

    initial begin
        forever #5 clock = ~clock;
    end

    // The prescaler runs fast so that tap 9 steps the phase every 64 cycles.
    always @(posedge clock) begin
        prescaler_tap <= prescaler_tap + 15'h10;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic peek(input logic [7:0] a, input logic [3:0] ix, input logic [3:0] exp);
        wr_reg(ADDR_INDEX, ix);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 check($sformatf("read %h.%h", a, ix), {16'h0, exp}, {16'h0, rdata});
    endtask

    function automatic logic [7:0] win(input int s);
        return (s < 16) ? ADDR_WIN_ONE : ADDR_WIN_TWO;
    endfunction

    task automatic verify_all();
        for (int s = 0; s < 20; s++) peek(win(s), 4'(s), shadow[s]);
    endtask

    task automatic frame(input logic [3:0] ctl, input logic [3:0] on_rows);
        logic [19:0] e;
        wr_reg(ADDR_CTRL_TWO, ctl);
        repeat (600) @(posedge clock);
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 20; s++) e[s] = shadow[s][k] & on_rows[k];
            check($sformatf("glass row %0d", k), e, rows[k]);
        end
    endtask

    // Counts rising edges of the multiplier clock over 256 cycles; with the
    // bench prescaler tap 10 has a period of 128 cycles, each lower tap half that.
    task automatic pump_rate(input logic [1:0] sel, input int exp);
        int n;
        logic last;
        n = 0;
        wr_reg(ADDR_CTRL_ONE, {2'h0, sel});
        repeat (8) @(posedge clock);
        #1 last = power.pump_clock;
        repeat (256) begin
            @(posedge clock);
            #1;
            if (power.pump_clock && !last) n++;
            last = power.pump_clock;
        end
        check("pump edges", 20'(exp), 20'(n));
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        por <= 1'b0;
        peek(ADDR_CTRL_ONE, 4'h0, 4'h0);
        peek(ADDR_CTRL_TWO, 4'h0, 4'he);
        check("reset segments", 20'h0, segment_out);
        check("reset backplanes", 20'h0, {16'h0, backplane_out});
        check("reset enable", 20'h0, {19'h0, power.enable});
        for (int s = 0; s < 20; s++) begin
            shadow[s] = 4'(s * 7 + 3);
            wr_reg(ADDR_INDEX, 4'(s));
            wr_reg(win(s), shadow[s]);
        end
        verify_all();
        wr_reg(ADDR_INDEX, 4'h9);
        wr_reg(ADDR_WIN_THREE, 4'h5);
        peek(ADDR_WIN_THREE, 4'h9, 4'h0);
        peek(8'h47, 4'h0, 4'h0);
        frame(4'h2, 4'hf);
        check("enable", 20'h1, {19'h0, power.enable});
        pump_rate(2'h0, 2);
        pump_rate(2'h1, 4);
        pump_rate(2'h2, 8);
        pump_rate(2'h3, 16);
        frame(4'h4, 4'h0);
        pump_rate(2'h0, 0);
        check("bias ground", 20'h7, {17'h0, bias_ground});
        check("shutdown", 20'h1, {19'h0, power.shutdown});
        verify_all();
        frame(4'h0, 4'h7);
        frame(4'h8, 4'h0);
        check("running", 20'h0, {19'h0, power.shutdown});
        pump_rate(2'h0, 2);
        wr_reg(ADDR_CTRL_ONE, 4'hf);
        wr_reg(ADDR_CTRL_TWO, 4'h1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        peek(ADDR_CTRL_ONE, 4'h0, 4'hc);
        peek(ADDR_CTRL_TWO, 4'h0, 4'hf);
        check("strobe route", 20'h3, {18'h0, power.strobe_route});
        check("external bias", 20'h1, {19'h0, power.external_bias_select});
        print_verdict();
    end
endmodule

`default_nettype wire
